// file: include/lmrsc_defs.svh
// Constants for the logic-module reset state control block.
`ifndef LMRSC_DEFS_SVH
`define LMRSC_DEFS_SVH

// Control register reset value and memory-space select bit positions.
`define LMRSC_REG_CLEAR       8'h00
`define LMRSC_MSS_PIO_BIT     7
`define LMRSC_MSS_SRAM_BIT    0
// Turbo control bit position in power management register zero.
`define LMRSC_TURBO_BIT       3
// Register map for the plain register port.
`define LMRSC_ADDR_PMR0       4'h0
`define LMRSC_ADDR_PMR2       4'h1
`define LMRSC_ADDR_MSS        4'h2
`define LMRSC_ADDR_CTRL0      4'h3
`define LMRSC_ADDR_CTRL1      4'h4
`define LMRSC_ADDR_STATUS     4'h5
// Flash mode encodings.
`define LMRSC_FLASH_READ      2'h0
`define LMRSC_FLASH_PROG      2'h1
`define LMRSC_FLASH_ERASE     2'h2

`endif

// file: include/lmrsc_pkg.sv
// Types for the logic-module reset state control block.
`default_nettype none
package lmrsc_pkg;
	// Reset sequencing states, Gray coded along the usual path.
	typedef enum logic [1:0] {
		LMRSC_ST_POWERUP = 2'b00,
		LMRSC_ST_RUN     = 2'b01,
		LMRSC_ST_WARM    = 2'b11,
		LMRSC_ST_APD     = 2'b10
	} lmrsc_state_t;
endpackage
`default_nettype wire

// file: rtl/lmrsc_core.sv
// Reset state control for the programmable logic and memory module.
`include "lmrsc_defs.svh"
`default_nettype none

// How it works
// [RQ1] Reset comes from the processor module and is active when low.
// [RQ2] Configuration loads during power-up reset; logic outputs follow equations meanwhile. Here logic output enables stay off until it is loaded.
// [RQ3] Any reset returns both flashes to read-array and aborts program or erase.
// [RQ4] Flash writes are blocked while supply is below the write lockout threshold.
// [RQ5] After the first power-up, every later reset counts as a warm reset.
// [RQ6] Processor I/O pins are inputs in resets and hold their state in power-down.
// [RQ7] Logic I/O pins follow equations; power-down blocks processor address into logic.
// [RQ8] Address-out and peripheral pins float in resets; peripheral pins float in power-down.
// [RQ9] Address-out pins are undefined in power-down since address inputs are blocked.
// [RQ10] During reset port pins in those modes are plain inputs without pull-ups.
// [RQ11] Power registers zero and two clear only at power-up; others clear on any reset.
// [RQ12] Macrocell flops clear at power-up; else follow their reset and preset equations.
// [RQ13] Memory-space select loads its initial value with bits 7 and 0 cleared.
// [RQ14] The test channel stays enabled in every reset and power-down state.
// [RQ15] Turbo control bit reads zero after power-up, giving full-speed logic.
// [RQ16] A power-on flag set by supply ramp clears once first reset is released.
// [RQ17] The incoming reset is synchronised before use.
module lmrsc_core
	import lmrsc_pkg::*;
#(
	parameter int          PORT_W      = 8,
	parameter int          MC_W        = 16,
	parameter logic [7:0]  MSS_INIT    = 8'h00
) (
	input  wire logic              clk_sys,
	input  wire logic              resetn,
	input  wire logic              supply_ramp_n,
	input  wire logic              module_rst_n,
	input  wire logic              supply_ok,
	input  wire logic              auto_power_down,
	input  wire logic              config_done,
	input  wire logic [1:0]        flash_cmd,
	input  wire logic              flash_cmd_valid,
	input  wire logic [PORT_W-1:0] port_is_mcu_io,
	input  wire logic [PORT_W-1:0] port_is_addr_out,
	input  wire logic [PORT_W-1:0] port_is_periph,
	input  wire logic [PORT_W-1:0] mcu_out_data,
	input  wire logic [PORT_W-1:0] mcu_out_en,
	input  wire logic [PORT_W-1:0] logic_out_data,
	input  wire logic [PORT_W-1:0] logic_out_en,
	input  wire logic [PORT_W-1:0] addr_latch_data,
	input  wire logic [PORT_W-1:0] periph_out_en,
	input  wire logic [MC_W-1:0]   mc_next,
	input  wire logic [MC_W-1:0]   flop_reset_equation,
	input  wire logic [MC_W-1:0]   flop_preset_equation,
	input  wire logic [3:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [7:0]             reg_rdata,
	output logic [1:0]             flash_mode,
	output logic                   flash_write_allow,
	output logic [PORT_W-1:0]      pin_out,
	output logic [PORT_W-1:0]      pin_oe,
	output logic [PORT_W-1:0]      pin_pullup_en,
	output logic                   addr_to_logic_en,
	output logic                   logic_outputs_valid,
	output logic [MC_W-1:0]        output_macrocell,
	output logic                   test_channel_en,
	output logic                   warm_reset,
	output logic                   power_on_flag
);

	// ------------------------------------------------------------
	// Reset and supply synchronisers
	// ------------------------------------------------------------
	logic [1:0]   rst_sync_reg;
	logic [1:0]   ok_sync_reg;
	logic [1:0]   apd_sync_reg;
	logic         in_reset;
	logic         in_apd;
	lmrsc_state_t state_reg;
	lmrsc_state_t state_next;
	logic         pon_reg;
	logic         cfg_loaded_reg;
	logic [7:0]   pmr0_reg;
	logic [7:0]   pmr2_reg;
	logic [7:0]   mss_reg;
	logic [7:0]   ctrl0_reg;
	logic [7:0]   ctrl1_reg;
	logic [1:0]   flash_mode_reg;
	logic [PORT_W-1:0] hold_out_reg;
	logic [PORT_W-1:0] hold_oe_reg;
	logic [MC_W-1:0]   mc_reg;
	logic [7:0]   rdata_reg;

	// Module reset and supply lines cross in through two flops each.
	always_ff @(posedge clk_sys) begin
		rst_sync_reg <= {rst_sync_reg[0], module_rst_n};  // see [RQ17]
		ok_sync_reg  <= {ok_sync_reg[0], supply_ok};
		apd_sync_reg <= {apd_sync_reg[0], auto_power_down};
	end

	assign in_reset = ~rst_sync_reg[1];  // Active low input asserted, see [RQ1]
	assign in_apd   = apd_sync_reg[1] & ~in_reset;

	// ------------------------------------------------------------
	// Power-on flag and reset classification
	// ------------------------------------------------------------
	// The flag only clears once reset is released with configuration loaded,
	// so a reset already low at power-up is still classed as power-up.
	always_ff @(posedge clk_sys) begin
		if (!resetn || !supply_ramp_n) begin
			pon_reg <= 1'b1;  // see [RQ16]
		end else if (pon_reg && !in_reset && state_reg == LMRSC_ST_POWERUP && cfg_loaded_reg) begin
			pon_reg <= 1'b0;  // see [RQ5]
		end
	end

	// Configuration is latched once config_done is seen after power-up, whether reset is held or not.
	always_ff @(posedge clk_sys) begin
		if (!resetn || !supply_ramp_n) begin
			cfg_loaded_reg <= 1'b0;
		end else if (config_done) begin
			cfg_loaded_reg <= 1'b1;  // see [RQ2]
		end
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			LMRSC_ST_POWERUP: if (!in_reset && cfg_loaded_reg) state_next = LMRSC_ST_RUN;
			LMRSC_ST_RUN: begin
				if (in_reset) state_next = LMRSC_ST_WARM;  // see [RQ5]
				else if (in_apd) state_next = LMRSC_ST_APD;
			end
			LMRSC_ST_WARM: if (!in_reset) state_next = LMRSC_ST_RUN;
			LMRSC_ST_APD: begin
				if (in_reset) state_next = LMRSC_ST_WARM;
				else if (!in_apd) state_next = LMRSC_ST_RUN;
			end
			default: state_next = LMRSC_ST_POWERUP;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn || !supply_ramp_n) begin
			state_reg <= LMRSC_ST_POWERUP;
		end else begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------
	// Flash mode and write lockout
	// ------------------------------------------------------------
	// Reset wins over any pending command, so an operation in flight is dropped.
	always_ff @(posedge clk_sys) begin
		if (!resetn || in_reset) begin
			flash_mode_reg <= `LMRSC_FLASH_READ;  // see [RQ3]
		end else if (flash_cmd_valid && (ok_sync_reg[1] || flash_cmd == `LMRSC_FLASH_READ)) begin
			flash_mode_reg <= flash_cmd;  // see [RQ4]
		end
	end

	assign flash_mode        = flash_mode_reg;
	assign flash_write_allow = ok_sync_reg[1] & ~in_reset;  // see [RQ4]

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	// Power management registers survive warm resets; control registers clear and memory-space select reloads on any reset.
	always_ff @(posedge clk_sys) begin
		if (!resetn || (in_reset && pon_reg)) begin
			pmr0_reg <= `LMRSC_REG_CLEAR;  // see [RQ11], see [RQ15]
			pmr2_reg <= `LMRSC_REG_CLEAR;
		end else if (reg_wr && !in_reset && !in_apd) begin
			if (reg_addr == `LMRSC_ADDR_PMR0) pmr0_reg <= reg_wdata;
			if (reg_addr == `LMRSC_ADDR_PMR2) pmr2_reg <= reg_wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn || in_reset) begin
			ctrl0_reg <= `LMRSC_REG_CLEAR;  // see [RQ11]
			ctrl1_reg <= `LMRSC_REG_CLEAR;
		end else if (reg_wr && !in_apd) begin
			if (reg_addr == `LMRSC_ADDR_CTRL0) ctrl0_reg <= reg_wdata;
			if (reg_addr == `LMRSC_ADDR_CTRL1) ctrl1_reg <= reg_wdata;
		end
	end

	// Memory-space select reloads its configured value, minus two bits.
	always_ff @(posedge clk_sys) begin
		if (!resetn || in_reset) begin
			mss_reg <= MSS_INIT;  // see [RQ13]
			mss_reg[`LMRSC_MSS_PIO_BIT]  <= 1'b0;
			mss_reg[`LMRSC_MSS_SRAM_BIT] <= 1'b0;
		end else if (reg_wr && !in_apd && reg_addr == `LMRSC_ADDR_MSS) begin
			mss_reg <= reg_wdata;
		end
	end

	// Read data stands in the cycle after the strobe; unmapped reads give zero.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			rdata_reg <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`LMRSC_ADDR_PMR0:   rdata_reg <= pmr0_reg;
				`LMRSC_ADDR_PMR2:   rdata_reg <= pmr2_reg;
				`LMRSC_ADDR_MSS:    rdata_reg <= mss_reg;
				`LMRSC_ADDR_CTRL0:  rdata_reg <= ctrl0_reg;
				`LMRSC_ADDR_CTRL1:  rdata_reg <= ctrl1_reg;
				`LMRSC_ADDR_STATUS: rdata_reg <= {3'h0, cfg_loaded_reg, ok_sync_reg[1], pon_reg, state_reg};
				default:            rdata_reg <= 8'h00;
			endcase
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	assign reg_rdata = rdata_reg;

	// ------------------------------------------------------------
	// Output macrocell flip-flops
	// ------------------------------------------------------------
	// Preset is given priority over the reset equation when both are true.
	always_ff @(posedge clk_sys) begin
		if (!resetn || (in_reset && pon_reg)) begin
			mc_reg <= '0;  // see [RQ12]
		end else begin
			for (int i = 0; i < MC_W; i++) begin
				if (flop_preset_equation[i]) mc_reg[i] <= 1'b1;  // see [RQ12]
				else if (flop_reset_equation[i]) mc_reg[i] <= 1'b0;
				else if (!in_reset && !in_apd) mc_reg[i] <= mc_next[i];
			end
		end
	end

	assign output_macrocell = mc_reg;

	// ------------------------------------------------------------
	// Port pin control
	// ------------------------------------------------------------
	// Processor I/O pins remember their last drive so power-down freezes them.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			hold_out_reg <= '0;
			hold_oe_reg  <= '0;
		end else if (!in_apd) begin
			hold_out_reg <= mcu_out_data;
			hold_oe_reg  <= mcu_out_en & {PORT_W{~in_reset}};  // see [RQ6]
		end
	end

	always_comb begin
		for (int i = 0; i < PORT_W; i++) begin
			if (port_is_periph[i]) begin
				pin_out[i] = 1'b0;
				pin_oe[i]  = periph_out_en[i] & ~in_reset & ~in_apd;  // see [RQ8]
			end else if (port_is_addr_out[i]) begin
				// Address drive is stale in power-down, so the pin level is meaningless.
				pin_out[i] = addr_latch_data[i];  // see [RQ9]
				pin_oe[i]  = ~in_reset;  // see [RQ8]
			end else if (port_is_mcu_io[i]) begin
				pin_out[i] = in_apd ? hold_out_reg[i] : mcu_out_data[i];
				pin_oe[i]  = in_apd ? hold_oe_reg[i] : (mcu_out_en[i] & ~in_reset);  // see [RQ6]
			end else begin
				pin_out[i] = logic_out_data[i];  // see [RQ7]
				pin_oe[i]  = logic_out_en[i] & (cfg_loaded_reg | ~pon_reg);  // see [RQ2]
			end
		end
	end

	// Module port pins never carry internal pull-ups.
	assign pin_pullup_en       = '0;  // see [RQ10]
	assign addr_to_logic_en    = ~in_apd;  // see [RQ7]
	assign logic_outputs_valid = cfg_loaded_reg | ~pon_reg;  // see [RQ2]
	assign test_channel_en     = 1'b1;  // see [RQ14]
	assign warm_reset          = in_reset & ~pon_reg;
	assign power_on_flag       = pon_reg;

endmodule
`default_nettype wire

// file: bench/lmrsc_core_properties.sv
// Concurrent checks on the reset state control block ports.
`default_nettype none
module lmrsc_core_props #(
	parameter int PORT_W = 8,
	parameter int MC_W   = 16
) (
	input wire logic              clk_sys,
	input wire logic              resetn,
	input wire logic              supply_ramp_n,
	input wire logic              module_rst_n,
	input wire logic              supply_ok,
	input wire logic              auto_power_down,
	input wire logic [PORT_W-1:0] port_is_mcu_io,
	input wire logic [PORT_W-1:0] port_is_addr_out,
	input wire logic [PORT_W-1:0] port_is_periph,
	input wire logic              reg_rd,
	input wire logic [7:0]        reg_rdata,
	input wire logic [1:0]        flash_mode,
	input wire logic              flash_write_allow,
	input wire logic [PORT_W-1:0] pin_oe,
	input wire logic [PORT_W-1:0] pin_pullup_en,
	input wire logic              addr_to_logic_en,
	input wire logic [MC_W-1:0]   output_macrocell,
	input wire logic              test_channel_en,
	input wire logic              warm_reset,
	input wire logic              power_on_flag
);
	// Four-cycle runs cover the two-flop synchroniser plus the registered response.
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	AST_NO_PULLUP: assert property (pin_pullup_en == '0) else $error("pull-up enabled");
	AST_TEST_CHAN: assert property (test_channel_en) else $error("test channel off");
	AST_WR_LOCK: assert property (!supply_ok [*3] |-> !flash_write_allow)
		else $error("flash write allowed below threshold");
	AST_RST_READ: assert property (!module_rst_n [*4] |=> flash_mode == 2'h0)
		else $error("flash not in read mode during reset");
	AST_RST_PINS: assert property (!module_rst_n [*4] |=>
		(pin_oe & (port_is_mcu_io | port_is_addr_out | port_is_periph)) == '0) else $error("pin driven in reset");
	AST_PUP_MC: assert property ((power_on_flag && !module_rst_n) [*4] |=> output_macrocell == '0)
		else $error("macrocell not cleared at power-up");
	AST_WARM: assert property ((!power_on_flag && !module_rst_n) [*4] |=> warm_reset)
		else $error("later reset not warm");
	AST_PON_STAYS: assert property (!power_on_flag && supply_ramp_n |=> !power_on_flag)
		else $error("power-on flag set without supply ramp");
	AST_APD_BLOCK: assert property ((auto_power_down && module_rst_n && !power_on_flag) [*4] |=>
		!addr_to_logic_en && (pin_oe & port_is_periph) == '0) else $error("power-down gating wrong");
	AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data outside slot");
	// Main scenarios reached.
	cover property ((!power_on_flag && !module_rst_n) [*4]);
	cover property (flash_mode == 2'h1);
	cover property (auto_power_down && !addr_to_logic_en);
endmodule
bind lmrsc_core lmrsc_core_props #(.PORT_W(PORT_W), .MC_W(MC_W)) props_u (.clk_sys, .resetn, .supply_ramp_n,
	.module_rst_n, .supply_ok, .auto_power_down, .port_is_mcu_io, .port_is_addr_out, .port_is_periph, .reg_rd,
	.reg_rdata, .flash_mode, .flash_write_allow, .pin_oe, .pin_pullup_en, .addr_to_logic_en, .output_macrocell,
	.test_channel_en, .warm_reset, .power_on_flag);
`default_nettype wire

// file: bench/lmrsc_supervisor.sv
// Behavioural model of the processor module's supervisory reset source.
`default_nettype none
module lmrsc_supervisor (
	input  wire logic clk_sys,
	input  wire logic supply_ramp_n,
	input  wire logic hold_req,
	output var logic  module_rst_n = 1'b0
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [4:0] pup_cnt_reg = 5'h00;
	// Reset is low, active, for 20 cycles after a supply ramp and while asked.
	always @(posedge clk_sys) begin
		if (!supply_ramp_n)
			pup_cnt_reg <= 5'h14;
		else if (pup_cnt_reg != 5'h00)
			pup_cnt_reg <= pup_cnt_reg - 5'h01;
		module_rst_n <= supply_ramp_n && (pup_cnt_reg == 5'h00) && !hold_req;
	end
endmodule
`default_nettype wire

// file: bench/test_lmrsc_core.sv
// Self-checking bench for the reset state control block.
`include "lmrsc_defs.svh"
`default_nettype none
module test_lmrsc_core;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] MSS_INIT = 8'hA5;
	logic        clk_sys = 1'b0, resetn = 1'b0, supply_ramp_n = 1'b0, supply_ok = 1'b0, auto_power_down = 1'b0;
	logic        config_done = 1'b0, flash_cmd_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, hold_req = 1'b0;
	logic        module_rst_n, flash_write_allow, addr_to_logic_en, logic_outputs_valid, test_channel_en;
	logic        warm_reset, power_on_flag, rd_pend = 1'b0;
	logic [1:0]  flash_cmd = 2'h0, flash_mode;
	logic [3:0]  reg_addr = 4'h0;
	logic [7:0]  reg_wdata = 8'h00, reg_rdata, port_is_mcu_io = 8'h00, port_is_addr_out = 8'h00, port_is_periph = 8'h00;
	logic [7:0]  mcu_out_data = 8'h00, mcu_out_en = 8'h00, logic_out_data = 8'h00, logic_out_en = 8'h00;
	logic [7:0]  addr_latch_data = 8'h00, periph_out_en = 8'h00, pin_out, pin_oe, pin_pullup_en, v, shadow [0:4];
	logic [15:0] mc_next = 16'h0000, flop_reset_equation = 16'h0000, flop_preset_equation = 16'h0000;
	logic [15:0] output_macrocell, mcp;
	logic [7:0]  exp_q [$];
	int          fail_count = 0, check_count = 0, cyc = 0;

	lmrsc_supervisor sup_u (.clk_sys, .supply_ramp_n, .hold_req, .module_rst_n);
	lmrsc_core #(.PORT_W(8), .MC_W(16), .MSS_INIT(MSS_INIT)) dut_u (.*);

	// Clock at 40 MHz.
	initial forever #12.5 clk_sys = ~clk_sys;

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic complete_run();
		if (fail_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// One register cycle: op 1 writes, 0 reads and notes the expected data, 2 idles.
	task automatic bus(input logic [1:0] op, input logic [3:0] a, input logic [7:0] d, input logic [7:0] e);
		reg_wr <= (op == 2'h1);
		reg_rd <= (op == 2'h0);
		reg_addr <= a;
		reg_wdata <= d;
		if (op == 2'h0)
			exp_q.push_back(e);
		@(posedge clk_sys);
	endtask

	// Flash mode is sampled two edges after the request; the command has no sync and the register lands on the first edge.
	task automatic fcmd(input logic [1:0] c, input logic [1:0] e);
		flash_cmd <= c;
		flash_cmd_valid <= 1'b1;
		@(posedge clk_sys);
		flash_cmd_valid <= 1'b0;
		@(posedge clk_sys);
		@(negedge clk_sys);
		chk("flash_mode", 16'(flash_mode), 16'(e));
		@(posedge clk_sys);
	endtask

	// Read data stand only in the cycle after the strobe, so the oldest note is compared then.
	always @(posedge clk_sys) rd_pend <= reg_rd;
	always @(negedge clk_sys) if (rd_pend) chk("reg_rdata", 16'(reg_rdata), 16'(exp_q.pop_front()));

	// Port modes and drive sources churn every cycle; the timeout also lives here.
	always @(posedge clk_sys) begin
		{port_is_mcu_io, port_is_addr_out, port_is_periph} <= 24'($urandom);
		{mcu_out_data, mcu_out_en, logic_out_data, logic_out_en} <= $urandom;
		{addr_latch_data, periph_out_en, mc_next} <= $urandom;
		cyc++;
		if (cyc == 2000) begin
			fail_count++;
			complete_run();
		end
	end

	initial begin
		void'($urandom(32'h1521));
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		supply_ramp_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		bus(2'h0, `LMRSC_ADDR_PMR0, 8'h00, 8'h00);
		bus(2'h0, `LMRSC_ADDR_MSS, 8'h00, MSS_INIT & 8'h7E);
		bus(2'h2, 4'h0, 8'h00, 8'h00);
		config_done <= 1'b1;
		chk("power_on_flag", 16'(power_on_flag), 16'h0001);
		for (int i = 0; i < 40 && power_on_flag !== 1'b0; i++) @(posedge clk_sys);
		chk("power_on_flag", 16'(power_on_flag), 16'h0000);
		// Status: config loaded, supply still low, flag clear, running.
		bus(2'h0, `LMRSC_ADDR_STATUS, 8'h00, 8'h11);
		// Back-to-back writes then reads of the five writable registers, plus an unmapped hole.
		for (int a = 0; a < 5; a++) begin
			shadow[a] = 8'($urandom);
			bus(2'h1, 4'(a), shadow[a], 8'h00);
		end
		for (int a = 0; a < 5; a++) bus(2'h0, 4'(a), 8'h00, shadow[a]);
		bus(2'h0, 4'hF, 8'h00, 8'h00);
		bus(2'h2, 4'h0, 8'h00, 8'h00);
		fcmd(`LMRSC_FLASH_PROG, `LMRSC_FLASH_READ);
		supply_ok <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk("flash_write_allow", 16'(flash_write_allow), 16'h0001);
		fcmd(`LMRSC_FLASH_PROG, `LMRSC_FLASH_PROG);
		fcmd(`LMRSC_FLASH_READ, `LMRSC_FLASH_READ);
		fcmd(`LMRSC_FLASH_ERASE, `LMRSC_FLASH_ERASE);
		// Warm reset in mid-erase with a random mask presetting its bits and resetting the rest.
		mcp = 16'($urandom);
		flop_preset_equation <= mcp;
		flop_reset_equation <= ~mcp;
		hold_req <= 1'b1;
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys);
		chk("flash_mode", 16'(flash_mode), 16'(`LMRSC_FLASH_READ));
		chk("warm_reset", 16'(warm_reset), 16'h0001);
		chk("output_macrocell", output_macrocell, mcp);
		// Moded pins float in reset while logic pins keep following their equations.
		chk("pin_oe_moded", 16'(pin_oe & (port_is_mcu_io | port_is_addr_out | port_is_periph)), 16'h0000);
		chk("pin_out_logic", 16'(pin_out & ~(port_is_mcu_io | port_is_addr_out | port_is_periph)),
			16'(logic_out_data & ~(port_is_mcu_io | port_is_addr_out | port_is_periph)));
		chk("pin_pullup_en", 16'(pin_pullup_en), 16'h0000);
		@(posedge clk_sys);
		bus(2'h0, `LMRSC_ADDR_PMR0, 8'h00, shadow[0]);
		bus(2'h0, `LMRSC_ADDR_PMR2, 8'h00, shadow[1]);
		bus(2'h0, `LMRSC_ADDR_MSS, 8'h00, MSS_INIT & 8'h7E);
		bus(2'h0, `LMRSC_ADDR_CTRL0, 8'h00, 8'h00);
		bus(2'h0, `LMRSC_ADDR_CTRL1, 8'h00, 8'h00);
		bus(2'h2, 4'h0, 8'h00, 8'h00);
		hold_req <= 1'b0;
		flop_preset_equation <= 16'h0000;
		flop_reset_equation <= 16'h0000;
		repeat (6) @(posedge clk_sys);
		// Power-down keeps registers and refuses writes.
		v = 8'($urandom);
		bus(2'h1, `LMRSC_ADDR_CTRL0, v, 8'h00);
		bus(2'h2, 4'h0, 8'h00, 8'h00);
		auto_power_down <= 1'b1;
		repeat (6) @(posedge clk_sys);
		chk("addr_to_logic_en", 16'(addr_to_logic_en), 16'h0000);
		chk("logic_outputs_valid", 16'(logic_outputs_valid), 16'h0001);
		bus(2'h1, `LMRSC_ADDR_CTRL0, ~v, 8'h00);
		bus(2'h0, `LMRSC_ADDR_CTRL0, 8'h00, v);
		bus(2'h0, `LMRSC_ADDR_PMR0, 8'h00, shadow[0]);
		bus(2'h2, 4'h0, 8'h00, 8'h00);
		auto_power_down <= 1'b0;
		repeat (4) @(posedge clk_sys);
		complete_run();
	end
endmodule
`default_nettype wire
